// File: src/cde_pkg.sv
package cde_pkg;

  // ---------------------------------------------------------------
  // Characters
  // ---------------------------------------------------------------
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_BELL = 8'h07;
  localparam logic [7:0] CH_SLASH = 8'h2F;
  localparam logic [7:0] CH_QM = 8'h3F;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_F = 8'h46;
  localparam logic [7:0] CH_LA = 8'h61;
  localparam logic [7:0] CH_LZ = 8'h7A;
  localparam logic [7:0] CASE_OFS = 8'h20;
  localparam logic [7:0] CH_B = 8'h42;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_D = 8'h44;
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CH_G = 8'h47;
  localparam logic [7:0] CH_I = 8'h49;
  localparam logic [7:0] CH_L = 8'h4C;
  localparam logic [7:0] CH_M = 8'h4D;
  localparam logic [7:0] CH_P = 8'h50;
  localparam logic [7:0] CH_V = 8'h56;
  localparam logic [7:0] CH_W = 8'h57;

  // ---------------------------------------------------------------
  // Error codes, printed as two hex digits
  // ---------------------------------------------------------------
  localparam logic [7:0] ERR_MISSING = 8'h44;
  localparam logic [7:0] ERR_SCR_PROT = 8'h45;
  localparam logic [7:0] ERR_RANGE = 8'h47;

  // ---------------------------------------------------------------
  // Address limits and option area layout
  // ---------------------------------------------------------------
  localparam int OPT_BYTES = 24;
  localparam logic [31:0] OPT_LAST_ADDR = 32'h0000_0017;
  localparam logic [31:0] GPR_LAST_ADDR = 32'h0000_000F;
  localparam logic [31:0] SCR_PROT_ADDR = 32'h0000_001F;
  localparam int OPT_SELFTEST = 3;
  localparam int OPT_NODE = 4;
  localparam int OPT_BAUD = 6;
  localparam int OPT_UNITS = 7;
  localparam int SELFTEST_DIS_BIT = 4;
  localparam int FPU_DIS_BIT = 0;
  localparam int BTB_DIS_BIT = 1;
  localparam int CACHE_DIS_BIT = 2;
  localparam logic [7:0] OPT_SELFTEST_RST = 8'h08;
  localparam logic [7:0] OPT_BAUD_RST = 8'h33;
  localparam logic [4:0] BAUD_CODE_HI = 5'h06;
  localparam logic [2:0] BAUD_IDX_DFLT = 3'h3;

  // ---------------------------------------------------------------
  // Timing: option write settle time
  // ---------------------------------------------------------------
  localparam int OPT_WRITE_MS = 10;
  localparam int CLK_KHZ = 250000;
  localparam int OPT_WAIT_CYC = OPT_WRITE_MS * CLK_KHZ;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SP_PHYS, SP_VIRT, SP_IPR, SP_GPR, SP_OPT, SP_SCR, SP_PSL
  } cde_space_e;
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} cde_size_e;
  typedef enum logic [1:0] {CMD_NONE, CMD_CONT, CMD_DEP, CMD_EXAM} cde_cmd_e;
  typedef enum logic [1:0] {PM_ECHO, PM_CRLF, PM_ERR, PM_EXAM} cde_pmode_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_PRINT = 3'b001, ST_EXEC = 3'b011,
    ST_ACCESS = 3'b010, ST_WAIT = 3'b110
  } cde_state_e;

  typedef struct packed {
    logic write;
    cde_space_e space;
    cde_size_e size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cde_acc_req_s;

  typedef struct packed {
    logic selftest_dis;
    logic [3:0] console_node;
    logic [2:0] baud_idx;
    logic fpu_dis;
    logic branch_target_buffer_dis;
    logic cache_dis;
  } cde_opt_cfg_s;

  function automatic logic [7:0] opt_reset_val(input int i);
    opt_reset_val = (i == OPT_SELFTEST) ? OPT_SELFTEST_RST :
                    (i == OPT_BAUD) ? OPT_BAUD_RST : 8'h00;
  endfunction

endpackage

// File: src/cde_console.sv
`timescale 1ns/1ps
module cde_console
  import cde_pkg::*;
#(
  parameter int unsigned OPT_WAIT_CYCLES = OPT_WAIT_CYC
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  output logic rx_ready_o,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  output logic acc_valid_o,
  output cde_acc_req_s acc_req_o,
  input wire logic acc_done_i,
  input wire logic [31:0] acc_rdata_i,
  input wire logic [31:0] acc_paddr_i,
  input wire logic map_enable_i,
  input wire logic panel_option_write_enable_i,
  input wire logic proc_init_i,
  input wire logic console_entry_i,
  input wire logic next_step_i,
  output logic cache_invalidate_o,
  output logic resume_o,
  output cde_opt_cfg_s opt_cfg_o
);

  if (OPT_WAIT_CYCLES < 1) begin : g_chk
    $error("OPT_WAIT_CYCLES must be at least 1");
  end

  // ---------------------------------------------------------------
  // Panel write-enable synchroniser
  // ---------------------------------------------------------------
  logic pwe_s1, pwe_s2, pwe_s3, pwe_ok;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pwe_s1 <= 1'b0;
      pwe_s2 <= 1'b0;
      pwe_s3 <= 1'b0;
      pwe_ok <= 1'b0;
    end else begin
      pwe_s1 <= panel_option_write_enable_i;
      pwe_s2 <= pwe_s1;
      pwe_s3 <= pwe_s2;
      if (pwe_s2 == pwe_s3) begin
        pwe_ok <= pwe_s3;
      end
    end
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  cde_state_e state;
  cde_pmode_e mode;
  logic [4:0] pos;
  logic [7:0] echo_ch, err_q;
  cde_cmd_e cmd;
  logic [1:0] field;
  logic qual_pend, have_addr, have_data, is_psl;
  logic space_set, size_set;
  cde_space_e space_q, dflt_space, disp_space;
  cde_size_e size_q, dflt_size, disp_size;
  logic [31:0] addr, data, dflt_addr, disp_addr, disp_data, wait_cnt;
  logic dflt_psl;
  logic [7:0] opt [OPT_BYTES];

  // ---------------------------------------------------------------
  // Character decode
  // ---------------------------------------------------------------
  logic [7:0] uc;
  logic is_dig, is_hex, q_sz_ok, q_sp_ok;
  logic ch_cmd, ch_qual, ch_slash, ch_sp, ch_arg, ch_good, take;
  logic [3:0] hex_nib;
  cde_size_e q_sz;
  cde_space_e q_sp;
  cde_cmd_e c_cmd;

  assign uc = (rx_data_i >= CH_LA && rx_data_i <= CH_LZ) ?
              rx_data_i - CASE_OFS : rx_data_i;
  assign is_dig = uc >= CH_0 && uc <= CH_9;
  assign is_hex = is_dig || (uc >= CH_A && uc <= CH_F);
  assign hex_nib = is_dig ? uc[3:0] : uc[3:0] + 4'h9;
  assign q_sz_ok = uc == CH_B || uc == CH_W || uc == CH_L;
  assign q_sz = (uc == CH_B) ? SZ_BYTE : (uc == CH_W) ? SZ_WORD : SZ_LONG;
  assign q_sp = (uc == CH_P) ? SP_PHYS : (uc == CH_V) ? SP_VIRT :
                (uc == CH_I) ? SP_IPR : (uc == CH_G) ? SP_GPR :
                (uc == CH_E) ? SP_OPT : SP_SCR;
  assign q_sp_ok = uc == CH_P || uc == CH_V || uc == CH_I || uc == CH_G ||
                   uc == CH_E || (uc == CH_M && cmd == CMD_EXAM);
  assign c_cmd = (uc == CH_C) ? CMD_CONT : (uc == CH_D) ? CMD_DEP :
                 (uc == CH_E) ? CMD_EXAM : CMD_NONE;
  assign ch_cmd = !qual_pend && cmd == CMD_NONE && c_cmd != CMD_NONE;
  assign ch_qual = qual_pend && (q_sz_ok || q_sp_ok);
  assign ch_slash = !qual_pend && rx_data_i == CH_SLASH &&
                    (cmd == CMD_DEP || cmd == CMD_EXAM);
  assign ch_sp = !qual_pend && rx_data_i == CH_SP &&
                 ((cmd == CMD_DEP && field < 2'd2) ||
                  (cmd == CMD_EXAM && field == 2'd0));
  assign ch_arg = !qual_pend && field != 2'd0 &&
                  (field == 2'd1 ? (!is_psl &&
                   (is_hex || (uc == CH_P && !have_addr))) : is_hex);
  assign ch_good = ch_cmd || ch_qual || ch_slash || ch_sp || ch_arg;
  assign take = rx_valid_i && rx_ready_o;

  // ---------------------------------------------------------------
  // Command evaluation
  // ---------------------------------------------------------------
  cde_space_e cur_space, eff_space, port_space;
  cde_size_e cur_size, eff_size;
  logic use_psl, long_only, err_any;
  logic [31:0] eff_addr, step;
  logic [7:0] err_code, opt_rd;

  assign cur_space = space_set ? space_q : dflt_space;
  assign cur_size = size_set ? size_q : dflt_size;
  assign use_psl = is_psl || (!have_addr && !space_set && dflt_psl &&
                   cmd == CMD_EXAM);
  assign eff_space = use_psl ? SP_PSL : cur_space;
  // The status longword has no numeric address; it always stands at 0
  assign eff_addr = use_psl ? 32'h0 :
                    have_addr ? addr : dflt_addr;
  assign long_only = eff_space inside {SP_IPR, SP_GPR, SP_SCR, SP_PSL};
  assign eff_size = long_only ? SZ_LONG :
                    (eff_space == SP_OPT) ? SZ_BYTE : cur_size;
  assign step = (eff_size == SZ_BYTE) ? 32'h1 :
                (eff_size == SZ_WORD) ? 32'h2 : 32'h4;
  assign port_space = (eff_space == SP_VIRT && !map_enable_i) ?
                      SP_PHYS : eff_space;
  assign err_code =
    (cmd == CMD_DEP && (!have_addr || !have_data)) ? ERR_MISSING :
    (cmd == CMD_DEP && eff_space == SP_OPT &&
     (eff_addr > OPT_LAST_ADDR || !pwe_ok)) ? ERR_RANGE :
    (eff_space == SP_GPR && eff_addr > GPR_LAST_ADDR) ? ERR_RANGE :
    (cmd == CMD_EXAM && eff_space == SP_SCR &&
     eff_addr == SCR_PROT_ADDR) ? ERR_SCR_PROT : 8'h00;
  assign err_any = err_code != 8'h00;
  assign opt_rd = (eff_addr <= OPT_LAST_ADDR) ?
                  opt[eff_addr[4:0]] : 8'h00;

  // ---------------------------------------------------------------
  // Output line composer
  // ---------------------------------------------------------------
  logic [4:0] nd, last_pos, a_idx, d_idx;
  logic [7:0] pr_ch, tag_ch;

  function automatic logic [7:0] hex_ch(input logic [3:0] n);
    hex_ch = (n < 4'hA) ? CH_0 + {4'h0, n} : CH_A + {4'h0, n} - 8'h0A;
  endfunction

  assign nd = (disp_size == SZ_BYTE) ? 5'd2 :
              (disp_size == SZ_WORD) ? 5'd4 : 5'd8;
  assign last_pos = (mode == PM_ECHO) ? 5'd0 : (mode == PM_CRLF) ? 5'd1 :
                    (mode == PM_ERR) ? 5'd4 : nd + 5'd12;
  assign a_idx = 5'd9 - pos;
  assign d_idx = nd + 5'd10 - pos;
  assign tag_ch = (disp_space == SP_IPR) ? CH_I :
                  (disp_space == SP_GPR) ? CH_G :
                  (disp_space == SP_OPT) ? CH_E :
                  (disp_space == SP_SCR) ? CH_M : CH_P;

  always_comb begin
    pr_ch = CH_LF;
    case (mode)
      PM_ECHO: pr_ch = echo_ch;
      PM_CRLF: pr_ch = (pos == 5'd0) ? CH_CR : CH_LF;
      PM_ERR: begin
        if (pos == 5'd0) pr_ch = CH_QM;
        else if (pos == 5'd1) pr_ch = hex_ch(err_q[7:4]);
        else if (pos == 5'd2) pr_ch = hex_ch(err_q[3:0]);
        else if (pos == 5'd3) pr_ch = CH_CR;
      end
      default: begin
        if (pos == 5'd0) pr_ch = tag_ch;
        else if (pos == 5'd1 || pos == 5'd10) pr_ch = CH_SP;
        else if (pos < 5'd10) pr_ch = hex_ch(disp_addr[a_idx[2:0]*4 +: 4]);
        else if (pos < nd + 5'd11)
          pr_ch = hex_ch(disp_data[d_idx[2:0]*4 +: 4]);
        else if (pos == nd + 5'd11) pr_ch = CH_CR;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Option byte decode
  // ---------------------------------------------------------------
  cde_opt_cfg_s cfg_next;
  logic [7:0] baud_b;
  assign baud_b = opt[OPT_BAUD];
  assign cfg_next.selftest_dis = opt[OPT_SELFTEST][SELFTEST_DIS_BIT];
  assign cfg_next.console_node = opt[OPT_NODE][3:0];
  assign cfg_next.baud_idx = (baud_b[7:3] == BAUD_CODE_HI) ?
                             baud_b[2:0] : BAUD_IDX_DFLT;
  assign cfg_next.fpu_dis = opt[OPT_UNITS][FPU_DIS_BIT];
  assign cfg_next.branch_target_buffer_dis = opt[OPT_UNITS][BTB_DIS_BIT];
  assign cfg_next.cache_dis = opt[OPT_UNITS][CACHE_DIS_BIT];

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) opt_cfg_o <= '0;
    else opt_cfg_o <= cfg_next;
  end

  // ---------------------------------------------------------------
  // Interpreter
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      mode <= PM_ECHO;
      pos <= 5'd0;
      echo_ch <= 8'h00;
      err_q <= 8'h00;
      cmd <= CMD_NONE;
      field <= 2'd0;
      qual_pend <= 1'b0;
      have_addr <= 1'b0;
      have_data <= 1'b0;
      is_psl <= 1'b0;
      space_set <= 1'b0;
      size_set <= 1'b0;
      space_q <= SP_PHYS;
      size_q <= SZ_LONG;
      addr <= 32'h0;
      data <= 32'h0;
      dflt_space <= SP_PHYS;
      dflt_size <= SZ_LONG;
      dflt_addr <= 32'h0;
      dflt_psl <= 1'b0;
      disp_space <= SP_PHYS;
      disp_size <= SZ_LONG;
      disp_addr <= 32'h0;
      disp_data <= 32'h0;
      wait_cnt <= 32'h0;
      for (int i = 0; i < OPT_BYTES; i++) opt[i] <= opt_reset_val(i);
      rx_ready_o <= 1'b0;
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
      acc_valid_o <= 1'b0;
      acc_req_o <= '0;
      cache_invalidate_o <= 1'b0;
      resume_o <= 1'b0;
    end else begin
      cache_invalidate_o <= 1'b0;
      resume_o <= 1'b0;
      rx_ready_o <= state == ST_IDLE && !take;
      case (state)
        ST_IDLE: begin
          if (take) begin
            state <= ST_PRINT;
            pos <= 5'd0;
            if (rx_data_i == CH_CR && !qual_pend) begin
              mode <= PM_CRLF;
            end else begin
              mode <= PM_ECHO;
              echo_ch <= ch_good ? rx_data_i : CH_BELL;
              if (ch_cmd) cmd <= c_cmd;
              if (ch_slash) qual_pend <= 1'b1;
              if (ch_sp) field <= field + 2'd1;
              if (ch_qual) begin
                qual_pend <= 1'b0;
                if (q_sz_ok) begin
                  size_q <= q_sz;
                  size_set <= 1'b1;
                end else begin
                  space_q <= q_sp;
                  space_set <= 1'b1;
                end
              end
              if (ch_arg && field == 2'd1) begin
                have_addr <= 1'b1;
                if (uc == CH_P) is_psl <= 1'b1;
                else addr <= {addr[27:0], hex_nib};
              end
              if (ch_arg && field == 2'd2) begin
                have_data <= 1'b1;
                data <= {data[27:0], hex_nib};
              end
            end
          end
        end
        ST_PRINT: begin
          if (!tx_valid_o) begin
            tx_valid_o <= 1'b1;
            tx_data_o <= pr_ch;
          end else if (tx_ready_i) begin
            tx_valid_o <= 1'b0;
            if (pos == last_pos) begin
              pos <= 5'd0;
              state <= (mode == PM_CRLF) ? ST_EXEC : ST_IDLE;
            end else begin
              pos <= pos + 5'd1;
            end
          end
        end
        ST_EXEC: begin
          cmd <= CMD_NONE;
          field <= 2'd0;
          have_addr <= 1'b0;
          have_data <= 1'b0;
          is_psl <= 1'b0;
          space_set <= 1'b0;
          size_set <= 1'b0;
          addr <= 32'h0;
          data <= 32'h0;
          state <= ST_IDLE;
          if (cmd == CMD_CONT) begin
            cache_invalidate_o <= 1'b1;
            resume_o <= 1'b1;
          end else if (cmd != CMD_NONE && err_any) begin
            err_q <= err_code;
            mode <= PM_ERR;
            state <= ST_PRINT;
          end else if (cmd != CMD_NONE) begin
            dflt_space <= cur_space;
            dflt_size <= cur_size;
            dflt_addr <= eff_addr + step;
            dflt_psl <= cmd == CMD_DEP && use_psl;
            disp_space <= eff_space;
            disp_size <= (eff_space == SP_OPT) ? cur_size : eff_size;
            disp_addr <= eff_addr;
            if (eff_space == SP_OPT && cmd == CMD_DEP) begin
              opt[eff_addr[4:0]] <= data[7:0];
              wait_cnt <= OPT_WAIT_CYCLES - 1;
              state <= ST_WAIT;
            end else if (eff_space == SP_OPT) begin
              disp_data <= {24'h0, opt_rd};
              mode <= PM_EXAM;
              state <= ST_PRINT;
            end else begin
              acc_valid_o <= 1'b1;
              acc_req_o.write <= cmd == CMD_DEP;
              acc_req_o.space <= port_space;
              acc_req_o.size <= eff_size;
              acc_req_o.addr <= eff_addr;
              acc_req_o.wdata <= data;
              state <= ST_ACCESS;
            end
          end
        end
        ST_ACCESS: begin
          if (acc_done_i) begin
            acc_valid_o <= 1'b0;
            state <= ST_IDLE;
            if (!acc_req_o.write) begin
              disp_data <= acc_rdata_i;
              if (disp_space == SP_VIRT && map_enable_i)
                disp_addr <= acc_paddr_i;
              mode <= PM_EXAM;
              state <= ST_PRINT;
            end
          end
        end
        ST_WAIT: begin
          if (wait_cnt == 32'h0) state <= ST_IDLE;
          else wait_cnt <= wait_cnt - 32'h1;
        end
        default: state <= ST_IDLE;
      endcase
      if (proc_init_i || console_entry_i || next_step_i) begin
        dflt_space <= SP_PHYS;
        dflt_size <= SZ_LONG;
        dflt_addr <= 32'h0;
        dflt_psl <= 1'b0;
      end
    end
  end

endmodule

// File: verification/cde_console_sva.sv
`timescale 1ns/1ps
module cde_console_sva
  import cde_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic rx_valid_i,
  input wire logic rx_ready_o,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic acc_valid_o,
  input wire cde_acc_req_s acc_req_o,
  input wire logic acc_done_i,
  input wire logic cache_invalidate_o,
  input wire logic resume_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_cont_paired: assert property (cache_invalidate_o |-> resume_o && !acc_valid_o)
    else $error("continue outputs not paired");
  a_cont_single: assert property (resume_o |=> !resume_o && !cache_invalidate_o)
    else $error("continue pulse too long");
  a_req_stands: assert property (acc_valid_o && !acc_done_i |=> acc_valid_o && $stable(acc_req_o))
    else $error("access request changed before done");
  a_req_ends: assert property (acc_done_i |=> !acc_valid_o)
    else $error("access request held after done");
  a_scratch_ro: assert property (acc_valid_o && acc_req_o.write |-> acc_req_o.space != SP_SCR)
    else $error("write to scratch space issued");
  a_scratch_prot: assert property (acc_valid_o && acc_req_o.space == SP_SCR |-> acc_req_o.addr != SCR_PROT_ADDR)
    else $error("protected scratch register accessed");
  a_long_only: assert property (acc_valid_o && acc_req_o.space inside {SP_IPR, SP_GPR, SP_SCR, SP_PSL} |-> acc_req_o.size == SZ_LONG)
    else $error("register access not longword");
  a_gpr_range: assert property (acc_valid_o && acc_req_o.space == SP_GPR |-> acc_req_o.addr <= GPR_LAST_ADDR)
    else $error("general register address out of range");
  a_tx_stands: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("transmit character dropped");
  a_rx_pause: assert property (rx_valid_i && rx_ready_o |=> !rx_ready_o [*2])
    else $error("receive not paused after byte");
endmodule

bind cde_console cde_console_sva u_sva (.clock_i, .rst_i, .rx_valid_i,
  .rx_ready_o, .tx_valid_o, .tx_data_o, .tx_ready_i, .acc_valid_o,
  .acc_req_o, .acc_done_i, .cache_invalidate_o, .resume_o);

// File: verification/cde_term.sv
`timescale 1ns/1ps
module cde_term (
  input wire logic clock_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  input wire logic rx_ready_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o
);
  logic [7:0] to_dut[$];
  logic [7:0] heard[$];
  logic slow = 1'h0;
  initial begin
    rx_valid_o = 1'h0;
    rx_data_o = 8'h00;
    tx_ready_o = 1'h1;
  end
  // -------------------------------------------------------------
  // Operator typing and screen capture
  // -------------------------------------------------------------
  task automatic type_line(input string s);
    for (int i = 0; i < s.len(); i++) begin
      to_dut.push_back(s[i]);
    end
  endtask
  always @(posedge clock_i) begin
    if (tx_valid_i && tx_ready_o) begin
      heard.push_back(tx_data_i);
    end
    tx_ready_o <= slow ? ~tx_ready_o : 1'h1;
    if (rx_valid_o && rx_ready_i) begin
      void'(to_dut.pop_front());
    end
    rx_valid_o <= (to_dut.size() > 0);
    // Idle line toggles so a stale character never looks valid
    rx_data_o <= (to_dut.size() > 0) ? to_dut[0] : ~rx_data_o;
  end
endmodule

// File: verification/tb.sv
`timescale 1ns/1ps
module tb;
  import cde_pkg::*;
  logic clock_i = 1'h0;
  logic rst_i = 1'h1;
  logic rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i;
  logic [7:0] rx_data_i, tx_data_o;
  logic acc_valid_o, cache_invalidate_o, resume_o;
  logic acc_done_i = 1'h0;
  logic [31:0] acc_rdata_i = 32'h0, acc_paddr_i = 32'h0;
  logic map_enable_i = 1'h0, panel_option_write_enable_i = 1'h0;
  logic proc_init_i = 1'h0, console_entry_i = 1'h0, next_step_i = 1'h0;
  cde_acc_req_s acc_req_o, last;
  cde_opt_cfg_s opt_cfg_o;
  int miscompares = 0, compares = 0, conts = 0, lat = 0;

  always #2 clock_i = ~clock_i;

  cde_console #(.OPT_WAIT_CYCLES(20)) u_dut (.clock_i, .rst_i, .rx_valid_i,
    .rx_data_i, .rx_ready_o, .tx_valid_o, .tx_data_o, .tx_ready_i,
    .acc_valid_o, .acc_req_o, .acc_done_i, .acc_rdata_i, .acc_paddr_i,
    .map_enable_i, .panel_option_write_enable_i, .proc_init_i,
    .console_entry_i, .next_step_i, .cache_invalidate_o, .resume_o,
    .opt_cfg_o);
  cde_term u_term (.clock_i(clock_i), .rx_valid_o(rx_valid_i),
    .rx_data_o(rx_data_i), .rx_ready_i(rx_ready_o), .tx_valid_i(tx_valid_o),
    .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i));

  // -------------------------------------------------------------
  // Processor side: answers after four cycles
  // -------------------------------------------------------------
  always @(posedge clock_i) begin
    acc_done_i <= 1'h0;
    acc_rdata_i <= ~acc_rdata_i;
    if (acc_valid_o && !acc_done_i) begin
      lat <= (lat == 3) ? 0 : lat + 1;
      if (lat == 3) begin
        acc_done_i <= 1'h1;
        acc_rdata_i <= 32'hC0DE_0000 + acc_req_o.addr;
        acc_paddr_i <= acc_req_o.addr + 32'h0000_0100;
        last <= acc_req_o;
      end
    end
    if (cache_invalidate_o) conts <= conts + 1;
  end

  // -------------------------------------------------------------
  // Checking tasks
  // -------------------------------------------------------------
  task automatic fail(input string m);
    miscompares++;
    $display("ERROR at %0t: %s", $time, m);
  endtask
  task automatic summarize();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) fail($sformatf("value %h expected %h", got, exp));
  endtask
  task automatic cmd(input string s, input string exp);
    string full;
    full = {s, "\r\n", exp};
    u_term.type_line({s, "\r"});
    for (int n = 0; u_term.heard.size() < full.len(); n++) begin
      if (n == 4000) begin
        fail({"no answer to ", s});
        summarize();
      end
      @(posedge clock_i);
    end
    repeat (40) @(posedge clock_i);
    compares++;
    if (u_term.heard.size() != full.len()) fail({"extra output after ", s});
    else foreach (u_term.heard[i]) begin
      if (u_term.heard[i] !== full[i]) fail({"wrong output for ", s});
    end
    u_term.heard.delete();
  endtask

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock_i);
    rst_i <= 1'h0;
    repeat (3) @(posedge clock_i);
    chk(32'(opt_cfg_o), 32'h018);
    cmd("E", "P 00000000 C0DE0000\r\n");
    cmd("E", "P 00000004 C0DE0004\r\n");
    cmd("E/B 10", "P 00000010 10\r\n");
    cmd("E", "P 00000011 11\r\n");
    cmd("E 20/W", "P 00000020 0020\r\n");
    cmd("E/I/B 5", "I 00000005 C0DE0005\r\n");
    cmd("E/G 3", "G 00000003 C0DE0003\r\n");
    cmd("E/G 1F", "?47\r\n");
    cmd("E/M 1E", "M 0000001E C0DE001E\r\n");
    cmd("E/M 1F", "?45\r\n");
    cmd("D 8", "?44\r\n");
    chk(32'(last.write), 32'h0);
    cmd("D/G 2 AB", "");
    chk({last.write, 28'(last.space), last.wdata[2:0]}, 32'h8000_001B);
    chk(last.wdata, 32'h0000_00AB);
    cmd("D P 5", "");
    chk(32'(last.space), 32'(SP_PSL));
    cmd("E", "P 00000000 C0DE0000\r\n");
    cmd("D/E 3 18", "?47\r\n");
    panel_option_write_enable_i <= 1'h1;
    repeat (5) @(posedge clock_i);
    cmd("D/E 18 0", "?47\r\n");
    cmd("D/E 3 18", "");
    cmd("D/E 4 5", "");
    cmd("D/E 6 37", "");
    cmd("D/E 7 5", "");
    chk(32'(opt_cfg_o), 32'h57D);
    panel_option_write_enable_i <= 1'h0;
    repeat (5) @(posedge clock_i);
    cmd("E/E/L 3", "E 00000003 00000018\r\n");
    cmd("E/E/W 6", "E 00000006 0037\r\n");
    map_enable_i <= 1'h1;
    cmd("E/V 40", "P 00000140 0040\r\n");
    map_enable_i <= 1'h0;
    for (int k = 0; k < 3; k++) begin
      cmd("E/W/V 30", "P 00000030 0030\r\n");
      {proc_init_i, console_entry_i, next_step_i} <= 3'h4 >> k;
      @(posedge clock_i);
      {proc_init_i, console_entry_i, next_step_i} <= 3'h0;
      cmd("E", "P 00000000 C0DE0000\r\n");
    end
    u_term.slow = 1'h1;
    cmd("C", "");
    chk(32'(conts), 32'h1);
    summarize();
  end
endmodule
